// [src/fifo_blk_pkg.sv]
package fifo_blk_pkg;

	// ----------------------------------------------------------------
	// storage geometry
	// ----------------------------------------------------------------
	localparam int unsigned BITS_TOTAL = 4608;
	localparam int unsigned DATA_W     = 18;
	localparam int unsigned ROWS       = BITS_TOTAL / DATA_W;
	localparam int unsigned ROW_AW     = 8;
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned CNT_W      = 13;
	localparam int unsigned LANE_W     = 9;
	localparam int unsigned TP_AW      = 9;

	typedef enum logic [2:0] {
		WIDTH_X1  = 3'h0,
		WIDTH_X2  = 3'h1,
		WIDTH_X4  = 3'h2,
		WIDTH_X9  = 3'h3,
		WIDTH_X18 = 3'h4
	} width_t;

	// ----------------------------------------------------------------
	// register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_DEPTH    = 8'h04;
	localparam logic [7:0] OFS_AE_THR   = 8'h08;
	localparam logic [7:0] OFS_AF_THR   = 8'h0c;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

	localparam int unsigned CTRL_MODE_BIT  = 0;
	localparam int unsigned CTRL_WW_LSB    = 1;
	localparam int unsigned CTRL_RW_LSB    = 4;
	localparam int unsigned CTRL_FLUSH_BIT = 7;
	localparam int unsigned CTRL_W         = 7;

	localparam logic [6:0]  CTRL_RST  = 7'h36;
	localparam logic [12:0] DEPTH_RST = 13'h0200;
	localparam logic [12:0] AE_RST    = 13'h0001;
	localparam logic [12:0] AF_RST    = 13'h01ff;

	localparam int unsigned ST_EMPTY   = 0;
	localparam int unsigned ST_FULL    = 1;
	localparam int unsigned ST_ALMOST_EMPTY_FLAG  = 2;
	localparam int unsigned ST_ALMOST_FULL_FLAG   = 3;
	localparam int unsigned ST_CNT_LSB = 16;

	localparam int unsigned EV_OVERFLOW  = 0;
	localparam int unsigned EV_UNDERFLOW = 1;
	localparam int unsigned EV_ALMOST_FULL_FLAG     = 2;
	localparam int unsigned EV_ALMOST_EMPTY_FLAG    = 3;
	localparam int unsigned EV_N         = 4;

	// ----------------------------------------------------------------
	// width helpers; unused codes behave as the widest port
	// ----------------------------------------------------------------
	function automatic logic [4:0] width_bits(input width_t w);
		case (w)
			WIDTH_X1: width_bits = 5'h01;
			WIDTH_X2: width_bits = 5'h02;
			WIDTH_X4: width_bits = 5'h04;
			WIDTH_X9: width_bits = 5'h09;
			default:  width_bits = 5'h12;
		endcase
	endfunction

	function automatic logic [12:0] max_words(input width_t w);
		case (w)
			WIDTH_X1: max_words = 13'h1000;
			WIDTH_X2: max_words = 13'h0800;
			WIDTH_X4: max_words = 13'h0400;
			WIDTH_X9: max_words = 13'h0200;
			default:  max_words = 13'h0100;
		endcase
	endfunction

endpackage

// [src/sram_fifo_block.sv]
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// [R1] the block stores exactly 4,608 bits whatever the port shapes; the x1, x2 and x4 ports reach only 4096 of them.
// [R2] ports can be 256x18, 512x9, 1kx4, 2kx2 or 4kx1.
// [R3] read and write ports are independent and each picks its own width; in fifo mode the read width follows the write width.
// [R4] contents can be preloaded through the test access port path.
// [R5] an internal controller makes the store a synchronous fifo.
// [R6] in fifo mode both data width and entry count are configured.
// [R7] almost-empty and almost-full flags use configured thresholds.
// [R8] empty shows no stored entries and full shows every entry taken.
// [R9] the controller counts its own read and write pointers.
// [R10] blocks can be combined in width or depth into larger stores.
// [R11] writes when full and reads when empty are dropped, pointers held.
// [R12] almost-empty is count<=threshold, almost-full is count>=threshold.

module sram_fifo_block (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// user write port
	input  wire logic        wr_en_i,
	input  wire logic [11:0] wr_addr_i,
	input  wire logic [17:0] wr_data_i,
	// user read port
	input  wire logic        rd_en_i,
	input  wire logic [11:0] rd_addr_i,
	output logic      [17:0] rd_data_o,
	output logic             rd_valid_o,
	// preload from user_test_port_macro
	input  wire logic        test_load_en_i,
	input  wire logic [8:0]  test_load_addr_i,
	input  wire logic [8:0]  test_load_data_i,
	// fifo flags and interrupt
	output logic             empty_o,
	output logic             full_o,
	output logic             almost_empty_flag_o,
	output logic             almost_full_flag_o,
	output logic             irq_o
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [6:0]  ctrl_q;
	logic [12:0] depth_q;
	logic [12:0] ae_thr_q;
	logic [12:0] af_thr_q;
	logic [3:0]  irq_stat_q;
	logic [3:0]  irq_stat_d;
	logic [3:0]  irq_mask_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic        flush_q;

	logic        wb_req;
	logic        wb_commit;
	logic [31:0] rd_mux;
	logic [31:0] wmask32;
	logic [31:0] wdata_m;

	assign wb_req    = wb_cyc_i && wb_stb_i && !ack_q;
	// writes take effect on the edge where the master sees ack
	assign wb_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
	assign wmask32   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdata_m   = wb_dat_i & wmask32;

	// ----------------------------------------------------------------
	// fifo state
	// ----------------------------------------------------------------
	logic [11:0] wptr_q;
	logic [11:0] rptr_q;
	logic [12:0] count_q;
	logic [12:0] count_d;
	logic [12:0] cap;
	logic        fifo_mode;
	fifo_blk_pkg::width_t ww;
	fifo_blk_pkg::width_t rw;
	logic        is_full;
	logic        is_empty;
	logic        wr_ok;
	logic        rd_ok;
	logic        wr_drop;
	logic        rd_drop;
	logic        ae_d;
	logic        af_d;
	logic        ae_q;
	logic        af_q;

	assign fifo_mode = ctrl_q[fifo_blk_pkg::CTRL_MODE_BIT];                 // [R5]
	assign ww = fifo_blk_pkg::width_t'(ctrl_q[fifo_blk_pkg::CTRL_WW_LSB +: 3]);
	// a fifo reads at its write width; direct mode allows a split shape
	assign rw = fifo_mode ? ww :
	            fifo_blk_pkg::width_t'(ctrl_q[fifo_blk_pkg::CTRL_RW_LSB +: 3]); // [R3]

	// entry count limited to what the chosen width can hold
	always_comb begin
		cap = depth_q;                                                      // [R6]
		if (cap > fifo_blk_pkg::max_words(ww)) begin
			cap = fifo_blk_pkg::max_words(ww);
		end
		if (cap == 13'h0000) begin
			cap = 13'h0001;
		end
	end

	assign is_full  = count_q >= cap;                                       // [R8]
	assign is_empty = count_q == 13'h0000;                                  // [R8]
	// in direct mode test loads own the write port; a clashing user write is dropped
	assign wr_ok    = wr_en_i && fifo_mode && !is_full;                    // [R11]
	assign rd_ok    = rd_en_i && fifo_mode && !is_empty;                   // [R11]
	assign wr_drop  = wr_en_i && fifo_mode && is_full;
	assign rd_drop  = rd_en_i && fifo_mode && is_empty;

	always_comb begin
		count_d = count_q;
		if (flush_q || !fifo_mode) begin
			count_d = 13'h0000;
		end else if (wr_ok && !rd_ok) begin
			count_d = count_q + 13'h0001;
		end else if (rd_ok && !wr_ok) begin
			count_d = count_q - 13'h0001;
		end
	end

	assign ae_d = count_d <= ae_thr_q;                                      // [R12] [R7]
	assign af_d = count_d >= af_thr_q;                                      // [R12] [R7]

	// pointers wrap at the configured entry count
	always_ff @(posedge clk_i) begin
		if (rst_i || flush_q || !fifo_mode) begin
			wptr_q <= 12'h000;
		end else if (wr_ok) begin                                           // [R9]
			wptr_q <= ({1'b0, wptr_q} == cap - 13'h0001) ? 12'h000 :
			          wptr_q + 12'h001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || flush_q || !fifo_mode) begin
			rptr_q <= 12'h000;
		end else if (rd_ok) begin                                           // [R9]
			rptr_q <= ({1'b0, rptr_q} == cap - 13'h0001) ? 12'h000 :
			          rptr_q + 12'h001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= 13'h0000;
		end else begin
			count_q <= count_d;
		end
	end

	// ----------------------------------------------------------------
	// flag outputs, registered from the next count
	// ----------------------------------------------------------------
	// flags are exported so several blocks can be chained by user logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			empty_o             <= 1'b1;
			full_o              <= 1'b0;
			almost_empty_flag_o <= 1'b1;
			almost_full_flag_o  <= 1'b0;
			ae_q                <= 1'b1;
			af_q                <= 1'b0;
		end else begin
			empty_o             <= count_d == 13'h0000;                         // [R8] [R10]
			full_o              <= count_d >= cap;                              // [R8] [R10]
			almost_empty_flag_o <= ae_d;                                        // [R7]
			almost_full_flag_o  <= af_d;                                        // [R7]
			ae_q                <= ae_d;
			af_q                <= af_d;
		end
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic        st_we;
	logic [2:0]  st_ww;
	logic [11:0] st_waddr;
	logic [17:0] st_wdata;
	logic        st_re;
	logic [11:0] st_raddr;

	// preload goes in as 9-bit lanes, ready for rom-like use
	always_comb begin
		if (test_load_en_i && !fifo_mode) begin                             // [R4]
			st_we    = 1'b1;
			st_ww    = fifo_blk_pkg::WIDTH_X9;
			st_waddr = {3'b000, test_load_addr_i};
			st_wdata = {9'h000, test_load_data_i};
		end else begin
			st_we    = fifo_mode ? wr_ok : wr_en_i;
			st_ww    = ww;
			st_waddr = fifo_mode ? wptr_q : wr_addr_i;                     // [R9]
			st_wdata = wr_data_i;
		end
	end

	assign st_re    = fifo_mode ? rd_ok : rd_en_i;
	assign st_raddr = fifo_mode ? rptr_q : rd_addr_i;

	sram_store u_store (                                                   // [R1] [R2]
		.clk_i      (clk_i),
		.we_i       (st_we),
		.wr_width_i (st_ww),
		.wr_addr_i  (st_waddr),
		.wr_data_i  (st_wdata),
		.re_i       (st_re),
		.rd_width_i (rw),
		.rd_addr_i  (st_raddr),
		.rd_data_o  (rd_data_o)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= st_re;
		end
	end

	// ----------------------------------------------------------------
	// interrupt events
	// ----------------------------------------------------------------
	logic [3:0] ev;
	logic [3:0] ev_clr;

	always_comb begin
		ev = 4'h0;
		ev[fifo_blk_pkg::EV_OVERFLOW]  = wr_drop;
		ev[fifo_blk_pkg::EV_UNDERFLOW] = rd_drop;
		ev[fifo_blk_pkg::EV_ALMOST_FULL_FLAG]     = af_d && !af_q;
		ev[fifo_blk_pkg::EV_ALMOST_EMPTY_FLAG]    = ae_d && !ae_q && fifo_mode;
	end

	assign ev_clr = (wb_commit && wb_adr_i == fifo_blk_pkg::OFS_IRQ_STAT) ?
	                wdata_m[3:0] : 4'h0;
	// an event in the clearing cycle survives the clear
	assign irq_stat_d = (irq_stat_q & ~ev_clr) | ev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= 4'h0;
			irq_o      <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_o      <= |(irq_stat_d & irq_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q     <= fifo_blk_pkg::CTRL_RST;
			depth_q    <= fifo_blk_pkg::DEPTH_RST;
			ae_thr_q   <= fifo_blk_pkg::AE_RST;
			af_thr_q   <= fifo_blk_pkg::AF_RST;
			irq_mask_q <= 4'h0;
		end else if (wb_commit) begin
			if (wb_adr_i == fifo_blk_pkg::OFS_CTRL) begin
				ctrl_q <= (ctrl_q & ~wmask32[6:0]) | wdata_m[6:0];
			end else if (wb_adr_i == fifo_blk_pkg::OFS_DEPTH) begin        // [R6]
				depth_q <= (depth_q & ~wmask32[12:0]) | wdata_m[12:0];
			end else if (wb_adr_i == fifo_blk_pkg::OFS_AE_THR) begin       // [R7]
				ae_thr_q <= (ae_thr_q & ~wmask32[12:0]) | wdata_m[12:0];
			end else if (wb_adr_i == fifo_blk_pkg::OFS_AF_THR) begin       // [R7]
				af_thr_q <= (af_thr_q & ~wmask32[12:0]) | wdata_m[12:0];
			end else if (wb_adr_i == fifo_blk_pkg::OFS_IRQ_MASK) begin
				irq_mask_q <= (irq_mask_q & ~wmask32[3:0]) | wdata_m[3:0];
			end
		end
	end

	// flush is a one-cycle pulse; the bit never reads back as set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flush_q <= 1'b0;
		end else begin
			flush_q <= wb_commit && wb_adr_i == fifo_blk_pkg::OFS_CTRL &&
			           wdata_m[fifo_blk_pkg::CTRL_FLUSH_BIT];
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (wb_adr_i == fifo_blk_pkg::OFS_CTRL) begin
			rd_mux[6:0] = ctrl_q;
		end else if (wb_adr_i == fifo_blk_pkg::OFS_DEPTH) begin
			rd_mux[12:0] = depth_q;
		end else if (wb_adr_i == fifo_blk_pkg::OFS_AE_THR) begin
			rd_mux[12:0] = ae_thr_q;
		end else if (wb_adr_i == fifo_blk_pkg::OFS_AF_THR) begin
			rd_mux[12:0] = af_thr_q;
		end else if (wb_adr_i == fifo_blk_pkg::OFS_STATUS) begin
			rd_mux[fifo_blk_pkg::ST_EMPTY]  = empty_o;
			rd_mux[fifo_blk_pkg::ST_FULL]   = full_o;
			rd_mux[fifo_blk_pkg::ST_ALMOST_EMPTY_FLAG] = almost_empty_flag_o;
			rd_mux[fifo_blk_pkg::ST_ALMOST_FULL_FLAG]  = almost_full_flag_o;
			rd_mux[fifo_blk_pkg::ST_CNT_LSB +: 13] = count_q;
		end else if (wb_adr_i == fifo_blk_pkg::OFS_IRQ_STAT) begin
			rd_mux[3:0] = irq_stat_q;
		end else if (wb_adr_i == fifo_blk_pkg::OFS_IRQ_MASK) begin
			rd_mux[3:0] = irq_mask_q;
		end
	end

	// every address is acked; unmapped ones read zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req;
			if (wb_req && !wb_we_i) begin
				dat_q <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

endmodule // sram_fifo_block

// [src/sram_store.sv]
`timescale 1ns/10ps

module sram_store (
	// clock
	input  wire logic        clk_i,
	// write port
	input  wire logic        we_i,
	input  wire logic [2:0]  wr_width_i,
	input  wire logic [11:0] wr_addr_i,
	input  wire logic [17:0] wr_data_i,
	// read port
	input  wire logic        re_i,
	input  wire logic [2:0]  rd_width_i,
	input  wire logic [11:0] rd_addr_i,
	output logic      [17:0] rd_data_o
);

	// ----------------------------------------------------------------
	// address mapping
	// ----------------------------------------------------------------
	// a row holds two 9-bit lanes; narrow ports use 8 bits of each lane,
	// so x1..x4 see 4096 bits while x9/x18 see all of them
	function automatic logic [12:0] locate(input logic [2:0] w,
	                                       input logic [11:0] a);
		logic [11:0] b;
		logic [8:0]  lane;
		b    = 12'h000;
		lane = 9'h000;
		case (fifo_blk_pkg::width_t'(w))
			fifo_blk_pkg::WIDTH_X1: b = a;
			fifo_blk_pkg::WIDTH_X2: b = {a[10:0], 1'b0};
			fifo_blk_pkg::WIDTH_X4: b = {a[9:0], 2'b00};
			default:                b = 12'h000;
		endcase
		case (fifo_blk_pkg::width_t'(w))
			fifo_blk_pkg::WIDTH_X9: locate = {a[8:1], 5'(a[0] ? 9 : 0)};
			fifo_blk_pkg::WIDTH_X1, fifo_blk_pkg::WIDTH_X2,
			fifo_blk_pkg::WIDTH_X4: begin
				lane   = b[11:3];
				locate = {lane[8:1], 5'(lane[0] ? 9 : 0) + {2'b00, b[2:0]}};
			end
			default: locate = {a[7:0], 5'h00};
		endcase
	endfunction

	logic [17:0] mem_q [0:fifo_blk_pkg::ROWS-1];
	logic [12:0] wloc;
	logic [12:0] rloc;
	logic [4:0]  wlen;
	logic [4:0]  rlen;
	logic [17:0] wmask;
	logic [17:0] rmask;
	logic [17:0] wshift;

	assign wloc   = locate(wr_width_i, wr_addr_i);
	assign rloc   = locate(rd_width_i, rd_addr_i);
	assign wlen   = fifo_blk_pkg::width_bits(fifo_blk_pkg::width_t'(wr_width_i));
	assign rlen   = fifo_blk_pkg::width_bits(fifo_blk_pkg::width_t'(rd_width_i));
	assign wshift = 18'(wr_data_i << wloc[4:0]);

	// ----------------------------------------------------------------
	// per-bit lane masks
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 18; i++) begin : g_mask
		assign wmask[i] = (5'(i) >= wloc[4:0]) &&
		                  (6'(i) < ({1'b0, wloc[4:0]} + {1'b0, wlen}));
		assign rmask[i] = 5'(i) < rlen;
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[wloc[12:5]] <= (mem_q[wloc[12:5]] & ~wmask) | (wshift & wmask);
		end
	end

	always_ff @(posedge clk_i) begin
		if (re_i) begin
			rd_data_o <= 18'(mem_q[rloc[12:5]] >> rloc[4:0]) & rmask;
		end
	end

endmodule // sram_store

// [tb/fifo_blk_asserts.sv]
`timescale 1ns/10ps
module fifo_blk_asserts (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register bus
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	// user ports and flags
	input  wire logic        wr_en_i,
	input  wire logic        rd_en_i,
	input  wire logic [17:0] rd_data_o,
	input  wire logic        rd_valid_o,
	input  wire logic        empty_o,
	input  wire logic        full_o,
	input  wire logic        almost_empty_flag_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_once;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	a_ack_next: assert property (s_req |=> s_ack_once)
		else $error("bus request not answered in one cycle");
	a_ack_cause: assert property (wb_ack_o |->
		$past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("bus answer without a request");
	a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
		else $error("bus read data moved outside a read");
	// a config write reaches the count one cycle after its ack
	a_full_hold: assert property (full_o && !rd_en_i && !wb_ack_o
		&& !$past(wb_ack_o) |=> full_o)
		else $error("full dropped without a read");
	a_empty_hold: assert property (empty_o && !wr_en_i && !wb_ack_o |=> empty_o)
		else $error("empty dropped without a write");
	a_valid_cause: assert property (rd_valid_o |-> $past(rd_en_i))
		else $error("read valid without a read request");
	a_rdata_hold: assert property ($changed(rd_data_o) |-> rd_valid_o)
		else $error("read data moved without valid");
	a_empty_ae: assert property (empty_o |-> almost_empty_flag_o)
		else $error("empty without almost empty");
	a_not_both: assert property (!(empty_o && full_o))
		else $error("empty and full together");
endmodule // fifo_blk_asserts

bind sram_fifo_block fifo_blk_asserts u_fifo_blk_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
	.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .empty_o(empty_o),
	.full_o(full_o), .almost_empty_flag_o(almost_empty_flag_o)
);

// [tb/fifo_user_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// fabric-side user logic driving both user ports
// ----------------------------------------------------------------
module fifo_user_model (
	// clock
	input  wire logic        clk_i,
	// requests from the bench
	input  wire logic        wr_req_i,
	input  wire logic        rd_req_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [17:0] data_i,
	// towards the block
	output logic             wr_en_o,
	output logic             rd_en_o,
	output logic      [11:0] wr_addr_o,
	output logic      [11:0] rd_addr_o,
	output logic      [17:0] wr_data_o
);
	initial begin
		{wr_en_o, rd_en_o} = 2'h0;
		{wr_addr_o, rd_addr_o, wr_data_o} = 42'h0;
	end

	// idle lines show the inverse of the last value, so a stale word
	// left on the bus can never be mistaken for fresh data
	always @(posedge clk_i) begin
		wr_en_o <= wr_req_i;
		rd_en_o <= rd_req_i;
		wr_addr_o <= wr_req_i ? addr_i : ~wr_addr_o;
		rd_addr_o <= rd_req_i ? addr_i : ~rd_addr_o;
		wr_data_o <= wr_req_i ? data_i : ~wr_data_o;
	end
endmodule // fifo_user_model

// [tb/sram_fifo_block_test.sv]
`timescale 1ns/10ps
module sram_fifo_block_test;
	localparam logic [31:0] NONE = 32'hffffffff;
	logic        clk_i, rst_i, cyc, stb, we, wb_ack_o;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, wb_dat_o;
	logic        wr_req, rd_req, wr_en, rd_en, rd_valid_o, tl_en;
	logic [11:0] addr, wr_addr, rd_addr;
	logic [17:0] wd, wr_data, rd_data_o;
	logic [8:0]  tl_addr, tl_data;
	logic        empty_o, full_o, ae, af, irq_o;
	int          n_mismatch, total_checks;

	sram_fifo_block u_sram_fifo_block (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wr_en_i(wr_en),
		.wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_en_i(rd_en),
		.rd_addr_i(rd_addr), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .test_load_en_i(tl_en),
		.test_load_addr_i(tl_addr), .test_load_data_i(tl_data),
		.empty_o(empty_o), .full_o(full_o), .almost_empty_flag_o(ae),
		.almost_full_flag_o(af), .irq_o(irq_o)
	);
	fifo_user_model u_fifo_user_model (
		.clk_i(clk_i), .wr_req_i(wr_req), .rd_req_i(rd_req),
		.addr_i(addr), .data_i(wd), .wr_en_o(wr_en), .rd_en_o(rd_en),
		.wr_addr_o(wr_addr), .rd_addr_o(rd_addr), .wr_data_o(wr_data)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] q);
		int k;
		@(posedge clk_i);
		{cyc, stb, we} <= {2'h3, w};
		adr <= a;
		wdat <= d;
		sel <= s;
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (wb_ack_o !== 1'b1) begin
			n_mismatch++;
			test_done();
		end
		@(posedge clk_i);
		q = wb_dat_o;
		{cyc, stb} <= 2'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m = 32'hffffffff);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, 4'hf, q);
		chk(q & m, e);
	endtask

	task automatic push(input logic [11:0] a, input logic [17:0] d,
			input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			wr_req <= 1'b1;
			addr <= a;
			wd <= d + 18'(i);
		end
		@(posedge clk_i);
		wr_req <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	// a refused read passes NONE and must show no valid at all
	task automatic pop(input logic [11:0] a, input logic [31:0] e);
		int k;
		@(posedge clk_i);
		rd_req <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd_req <= 1'b0;
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
		end while (rd_valid_o !== 1'b1 && k < 8);
		chk({31'h0, rd_valid_o}, {31'h0, e !== NONE});
		if (e !== NONE) chk({14'h0, rd_data_o}, e);
	endtask

	task automatic flags(input logic [3:0] e);
		@(negedge clk_i);
		chk({28'h0, empty_o, full_o, ae, af}, {28'h0, e});
	endtask

	task automatic irq_is(input logic e);
		repeat (2) @(negedge clk_i);
		chk({31'h0, irq_o}, {31'h0, e});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] q;
		rd(fifo_blk_pkg::OFS_CTRL, 32'h36);
		rd(fifo_blk_pkg::OFS_DEPTH, 32'h200);
		rd(fifo_blk_pkg::OFS_AE_THR, 32'h1);
		rd(fifo_blk_pkg::OFS_IRQ_MASK, 32'h0);
		rd(8'h1c, 32'h0);
		flags(4'b1010);
		wb(1'b1, fifo_blk_pkg::OFS_AF_THR, 32'h0203, 4'h1, q);
		rd(fifo_blk_pkg::OFS_AF_THR, 32'h103);
		$display("t_regs done");
	endtask

	task automatic t_fifo();
		logic [3:0] fl [4] = '{4'b0001, 4'b0000, 4'b0010, 4'b1010};
		wr(fifo_blk_pkg::OFS_CTRL, 32'h37);
		wr(fifo_blk_pkg::OFS_DEPTH, 32'h4);
		wr(fifo_blk_pkg::OFS_AE_THR, 32'h1);
		wr(fifo_blk_pkg::OFS_AF_THR, 32'h3);
		pop(12'h0, NONE);
		irq_is(1'b0);
		rd(fifo_blk_pkg::OFS_IRQ_STAT, 32'h2, 32'h3);
		wr(fifo_blk_pkg::OFS_IRQ_MASK, 32'h3);
		irq_is(1'b1);
		wr(fifo_blk_pkg::OFS_IRQ_STAT, 32'h2);
		irq_is(1'b0);
		push(12'h0, 18'h100, 4);
		flags(4'b0101);
		rd(fifo_blk_pkg::OFS_STATUS, 32'h0004000a);
		push(12'h0, 18'h1aa, 1);
		rd(fifo_blk_pkg::OFS_STATUS, 32'h0004000a);
		irq_is(1'b1);
		wr(fifo_blk_pkg::OFS_IRQ_STAT, 32'hf);
		irq_is(1'b0);
		for (int i = 0; i < 4; i++) begin
			pop(12'h0, 32'h100 + 32'(i));
			chk({28'h0, empty_o, full_o, ae, af}, {28'h0, fl[i]});
		end
		pop(12'h0, NONE);
		// flush drops the stored entries and rewinds both pointers
		push(12'h0, 18'h155, 3);
		pop(12'h0, 32'h155);
		wr(fifo_blk_pkg::OFS_CTRL, 32'hb7);
		rd(fifo_blk_pkg::OFS_STATUS, 32'h5);
		rd(fifo_blk_pkg::OFS_CTRL, 32'h37);
		push(12'h0, 18'h0aa, 1);
		pop(12'h0, 32'h0aa);
		$display("t_fifo done");
	endtask

	task automatic t_direct();
		logic [17:0] m [5] = '{18'h1, 18'h3, 18'hf, 18'h1ff, 18'h3ffff};
		for (int w = 0; w < 5; w++) begin
			wr(fifo_blk_pkg::OFS_CTRL, {25'h0, 3'(w), 3'(w), 1'b0});
			push(12'h1, 18'h2d5a5 & m[w], 1);
			pop(12'h1, {14'h0, 18'h2d5a5 & m[w]});
		end
		// written nine bits wide, read back one bit at a time
		wr(fifo_blk_pkg::OFS_CTRL, 32'h06);
		push(12'h2, 18'h0a5, 1);
		pop(12'h010, 32'h1);
		pop(12'h011, 32'h0);
		pop(12'h012, 32'h1);
		wr(fifo_blk_pkg::OFS_CTRL, 32'h36);
		@(posedge clk_i);
		{wr_req, addr, wd} <= {1'b1, 12'h5, 18'h0ff};
		@(posedge clk_i);
		{wr_req, tl_en, tl_addr, tl_data} <= {2'h1, 9'h5, 9'h13c};
		@(posedge clk_i);
		{tl_en, tl_addr, tl_data} <= {1'b0, ~tl_addr, ~tl_data};
		pop(12'h5, 32'h13c);
		$display("t_direct done");
	endtask

	// ----------------------------------------------------------------
	// clock, reset and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		{rst_i, cyc, stb, we, wr_req, rd_req, tl_en} = 7'h40;
		{adr, sel, wdat, addr, wd, tl_addr, tl_data} = 80'h0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_fifo();
		t_direct();
		test_done();
	end
endmodule // sram_fifo_block_test
